/* File: rtl/ccds_divider.sv */
`timescale 1ns/100ps
module ccds_divider
   import ccds_pkg::*;
(
   // System
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // Select in, tick out
   ccds_div_if.div bus
);
   import ccds_pkg::*;

   ccds_cnt_t count_ff;
   ccds_cnt_t nxt_count;
   ccds_sel_t actSel_ff;
   ccds_sel_t nxt_actSel;
   logic tick;

   // New ratio is taken only where the running period ends
   always_comb
   begin
      nxt_count = count_ff;
      nxt_actSel = actSel_ff;
      tick = (count_ff >= ccds_ratio_last(actSel_ff));
      if (tick)
      begin
         nxt_count = CCDS_CNT_ZERO;
         nxt_actSel = bus.reqSel;
      end
      else
      begin
         nxt_count = count_ff + CCDS_CNT_ONE;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         count_ff <= CCDS_CNT_ZERO;
         actSel_ff <= CCDS_SEL_RESET;
      end
      else if (ce)
      begin
         count_ff <= nxt_count;
         actSel_ff <= nxt_actSel;
      end
   end

   assign bus.tick = tick;
   assign bus.actSel = actSel_ff;

   // Cycles since the previous tick, for the checks only
   logic [4:0] gapCnt_ff;
   logic seenTick_ff;
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         gapCnt_ff <= 5'h00;
         seenTick_ff <= 1'b0;
      end
      else if (ce)
      begin
         gapCnt_ff <= tick ? 5'h00 : gapCnt_ff + 5'h01;
         seenTick_ff <= seenTick_ff | tick;
      end
   end

   AST_SWITCH_AT_BOUNDARY: assert property (
      @(posedge clk) disable iff (!nrst)
      ce && !tick |=> actSel_ff == $past(actSel_ff))
      else $error("divider ratio changed inside a period");

   AST_PERIOD_MATCH: assert property (
      @(posedge clk) disable iff (!nrst)
      ce && tick && seenTick_ff |-> {1'b0, ccds_ratio_last(actSel_ff)} == gapCnt_ff)
      else $error("period length differs from the ratio in force");

   AST_DIV16_GAP: assert property (
      @(posedge clk) disable iff (!nrst)
      ce && tick && bus.reqSel == CCDS_SEL_DIV16 ##1 ce[*3] |-> !tick)
      else $error("divide by sixteen ticked too early");

endmodule // ccds_divider

/* File: rtl/ccds_top.sv */
`timescale 1ns/100ps
// Notes on behaviour
// - Reset loads the control register with 01H: CPU clock is main clock over two.
// - Select codes 000 to 100 give divide by 1, 2, 4, 8, 16.
// - Peripheral clock is never divided, whatever ratio is chosen.
// - Register takes whole-byte writes and single-bit writes to bits 2..0 only.
module ccds_top
   import ccds_pkg::*;
(
   // System
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // CPU memory access
   input wire logic [15:0] cpuAddr,
   input wire logic cpuWrEn,
   input wire logic cpuBitOp,
   input wire logic [2:0] cpuBitIdx,
   input wire logic [7:0] cpuWrData,
   input wire logic cpuRdEn,
   output logic [7:0] cpuRdData,
   // Clock enables and status
   output logic cpuClkEn,
   output logic periphClkEn,
   output logic [2:0] cpuDivActive,
   output logic cpuDivPending
);
   import ccds_pkg::*;

   ccds_div_if divBus ();

   ccds_sel_t ctlSel_ff;
   ccds_sel_t nxt_ctlSel;
   logic [7:0] rdData_ff;
   logic [7:0] nxt_rdData;
   logic cpuClkEn_ff;
   logic nxt_cpuClkEn;
   logic periphClkEn_ff;
   logic nxt_periphClkEn;
   ccds_sel_t divActive_ff;
   ccds_sel_t nxt_divActive;
   logic divPending_ff;
   logic nxt_divPending;
   logic regHit;

   ccds_divider u_divider (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .bus(divBus)
   );

   assign divBus.reqSel = ctlSel_ff;

   // Register write and read path
   always_comb
   begin
      regHit = (cpuAddr == CCDS_CTL_ADDR);
      nxt_ctlSel = ctlSel_ff;
      nxt_rdData = CCDS_RD_IDLE;
      if (cpuWrEn && regHit)
      begin
         if (cpuBitOp)
         begin
            // Bits above the field are fixed at zero, so bit writes there do nothing
            if (cpuBitIdx <= CCDS_BIT_SEL_TOP)
            begin
               nxt_ctlSel[cpuBitIdx[1:0]] = cpuWrData[0];
            end
         end
         else
         begin
            nxt_ctlSel = cpuWrData[CCDS_SEL_W-1:0];
         end
      end
      if (cpuRdEn && regHit)
      begin
         nxt_rdData = {CCDS_UPPER_ZERO, ctlSel_ff};
      end
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         ctlSel_ff <= CCDS_SEL_RESET;
         rdData_ff <= CCDS_RD_IDLE;
      end
      else if (ce)
      begin
         ctlSel_ff <= nxt_ctlSel;
         rdData_ff <= nxt_rdData;
      end
   end

   // Clock enables; consumers must also gate with ce since the outputs freeze with it
   always_comb
   begin
      nxt_cpuClkEn = divBus.tick;
      nxt_periphClkEn = 1'b1;
      nxt_divActive = divBus.actSel;
      nxt_divPending = (ctlSel_ff != divBus.actSel);
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         cpuClkEn_ff <= 1'b0;
         periphClkEn_ff <= 1'b0;
         divActive_ff <= CCDS_SEL_RESET;
         divPending_ff <= 1'b0;
      end
      else if (ce)
      begin
         cpuClkEn_ff <= nxt_cpuClkEn;
         periphClkEn_ff <= nxt_periphClkEn;
         divActive_ff <= nxt_divActive;
         divPending_ff <= nxt_divPending;
      end
   end

   assign cpuRdData = rdData_ff;
   assign cpuClkEn = cpuClkEn_ff;
   assign periphClkEn = periphClkEn_ff;
   assign cpuDivActive = divActive_ff;
   assign cpuDivPending = divPending_ff;

   AST_CTL_RESET: assert property (
      @(posedge clk)
      !nrst |=> ctlSel_ff == CCDS_SEL_RESET && divActive_ff == CCDS_SEL_RESET)
      else $error("reset did not load divide by two");

   AST_RESET_READ: assert property (
      @(posedge clk)
      !nrst ##1 nrst && ce && cpuRdEn && regHit && !cpuWrEn |=> cpuRdData == CCDS_CTL_RESET)
      else $error("first read after reset is not the reset value");

   AST_BYTE_WRITE: assert property (
      @(posedge clk) disable iff (!nrst)
      ce && cpuWrEn && regHit && !cpuBitOp
      |=> ctlSel_ff == $past(cpuWrData[2:0]))
      else $error("byte write not stored");

   AST_BIT_WRITE: assert property (
      @(posedge clk) disable iff (!nrst)
      ce && cpuWrEn && regHit && cpuBitOp && cpuBitIdx <= CCDS_BIT_SEL_TOP
      |=> ctlSel_ff[$past(cpuBitIdx[1:0])] == $past(cpuWrData[0])
          && ((ctlSel_ff ^ $past(ctlSel_ff)) & ~(3'h1 << $past(cpuBitIdx))) == 3'h0)
      else $error("bit write touched the wrong bits");

   AST_READ_UPPER_ZERO: assert property (
      @(posedge clk) disable iff (!nrst)
      ce && cpuRdEn && regHit |=> cpuRdData == {CCDS_UPPER_ZERO, $past(ctlSel_ff)})
      else $error("read data wrong or upper bits not zero");

   AST_PERIPH_UNDIVIDED: assert property (
      @(posedge clk) disable iff (!nrst)
      $past(nrst) && $past(ce) |-> periphClkEn)
      else $error("peripheral clock enable dropped");

   AST_DIV1_EVERY_CYCLE: assert property (
      @(posedge clk) disable iff (!nrst)
      $past(nrst) && $past(ce) && cpuDivActive == CCDS_SEL_DIV1 |-> cpuClkEn)
      else $error("divide by one missed a cycle");

   AST_DIV2_ALTERNATE: assert property (
      @(posedge clk) disable iff (!nrst)
      ce && cpuClkEn && cpuDivActive == CCDS_SEL_DIV2 && ctlSel_ff == CCDS_SEL_DIV2
      ##1 ce |-> !cpuClkEn)
      else $error("divide by two ticked on consecutive cycles");

   AST_UNMAPPED_WRITE: assert property (
      @(posedge clk) disable iff (!nrst)
      ce && cpuWrEn && !regHit |=> ctlSel_ff == $past(ctlSel_ff))
      else $error("write to another address changed the register");

   AST_HIGH_BIT_WRITE: assert property (
      @(posedge clk) disable iff (!nrst)
      ce && cpuWrEn && regHit && cpuBitOp && cpuBitIdx > CCDS_BIT_SEL_TOP
      |=> ctlSel_ff == $past(ctlSel_ff))
      else $error("bit write above the field changed the register");

   AST_READ_IDLE: assert property (
      @(posedge clk) disable iff (!nrst)
      ce && !(cpuRdEn && regHit) |=> cpuRdData == CCDS_RD_IDLE)
      else $error("read data not idle without a read");

   AST_RESET_OUTPUTS: assert property (
      @(posedge clk)
      !nrst |=> !cpuClkEn && cpuRdData == CCDS_RD_IDLE && !cpuDivPending)
      else $error("outputs not cleared by reset");

   // Guarded by nrst, since reset acts even while ce is low
   AST_FREEZE: assert property (
      @(posedge clk) disable iff (!nrst)
      nrst && !ce |=> $stable(ctlSel_ff) && $stable(cpuClkEn) && $stable(cpuDivActive))
      else $error("state moved while clock enable was low");

endmodule // ccds_top

/* File: shared/ccds_div_if.sv */
`timescale 1ns/100ps
interface ccds_div_if;
   logic [2:0] reqSel;
   logic [2:0] actSel;
   logic tick;

   modport ctl (output reqSel, input actSel, input tick);
   modport div (input reqSel, output actSel, output tick);
endinterface

/* File: shared/ccds_pkg.sv */
package ccds_pkg;

   // CPU memory address of the processor clock control register
   localparam logic [15:0] CCDS_CTL_ADDR = 16'hFFFB;
   // Register value after reset
   localparam logic [7:0] CCDS_CTL_RESET = 8'h01;
   // Divider select field: bits 2..0, bits 7..3 always zero
   localparam int CCDS_SEL_W = 3;
   localparam logic [2:0] CCDS_SEL_RESET = CCDS_CTL_RESET[2:0];
   localparam logic [2:0] CCDS_BIT_SEL_TOP = 3'h2;
   localparam logic [4:0] CCDS_UPPER_ZERO = 5'h00;
   localparam logic [7:0] CCDS_RD_IDLE = 8'h00;
   // Divider select codes
   localparam logic [2:0] CCDS_SEL_DIV1 = 3'h0;
   localparam logic [2:0] CCDS_SEL_DIV2 = 3'h1;
   localparam logic [2:0] CCDS_SEL_DIV4 = 3'h2;
   localparam logic [2:0] CCDS_SEL_DIV8 = 3'h3;
   localparam logic [2:0] CCDS_SEL_DIV16 = 3'h4;
   // Last count of a divider period, one less than the ratio
   localparam int CCDS_CNT_W = 4;
   localparam logic [3:0] CCDS_LAST_DIV1 = 4'h0;
   localparam logic [3:0] CCDS_LAST_DIV2 = 4'h1;
   localparam logic [3:0] CCDS_LAST_DIV4 = 4'h3;
   localparam logic [3:0] CCDS_LAST_DIV8 = 4'h7;
   localparam logic [3:0] CCDS_LAST_DIV16 = 4'hF;
   localparam logic [3:0] CCDS_CNT_ZERO = 4'h0;
   localparam logic [3:0] CCDS_CNT_ONE = 4'h1;

   typedef logic [CCDS_SEL_W-1:0] ccds_sel_t;
   typedef logic [CCDS_CNT_W-1:0] ccds_cnt_t;

   // Prohibited codes fall back to the slowest ratio
   function automatic ccds_cnt_t ccds_ratio_last(input ccds_sel_t sel);
      ccds_cnt_t last;
      case (sel)
         CCDS_SEL_DIV1: last = CCDS_LAST_DIV1;
         CCDS_SEL_DIV2: last = CCDS_LAST_DIV2;
         CCDS_SEL_DIV4: last = CCDS_LAST_DIV4;
         CCDS_SEL_DIV8: last = CCDS_LAST_DIV8;
         default: last = CCDS_LAST_DIV16;
      endcase
      return last;
   endfunction

endpackage

/* File: verification/testbench.sv */
`timescale 1ns/100ps
module testbench;
   import ccds_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b1;
   logic [15:0] cpuAddr = 16'h0000;
   logic cpuWrEn = 1'b0;
   logic cpuBitOp = 1'b0;
   logic [2:0] cpuBitIdx = 3'h0;
   logic [7:0] cpuWrData = 8'h00;
   logic cpuRdEn = 1'b0;
   logic [7:0] cpuRdData;
   logic cpuClkEn;
   logic periphClkEn;
   logic [2:0] cpuDivActive;
   logic cpuDivPending;
   int n_errors = 0;
   int checked = 0;
   logic [7:0] rv;
   int n;

   ccds_top dut (.clk(clk), .nrst(nrst), .ce(ce), .cpuAddr(cpuAddr), .cpuWrEn(cpuWrEn),
      .cpuBitOp(cpuBitOp), .cpuBitIdx(cpuBitIdx), .cpuWrData(cpuWrData), .cpuRdEn(cpuRdEn),
      .cpuRdData(cpuRdData), .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn),
      .cpuDivActive(cpuDivActive), .cpuDivPending(cpuDivPending));

   always #5 clk = ~clk;

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic b, input logic [2:0] i,
      input logic [7:0] d);
      @(posedge clk);
      cpuAddr <= a;
      cpuBitOp <= b;
      cpuBitIdx <= i;
      cpuWrData <= d;
      cpuWrEn <= 1'b1;
      @(posedge clk);
      cpuWrEn <= 1'b0;
   endtask

   // Read data is registered, so it is sampled just after the taking edge
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk);
      cpuAddr <= a;
      cpuRdEn <= 1'b1;
      @(posedge clk);
      cpuRdEn <= 1'b0;
      #1;
      d = cpuRdData;
   endtask

   // Cycles between two enable pulses, bounded so a dead divider cannot hang
   task automatic period(output int p);
      int i;
      @(posedge clk);
      #1;
      for (i = 0; i < 40 && cpuClkEn !== 1'b1; i++)
      begin
         @(posedge clk);
         #1;
      end
      p = 0;
      do
      begin
         @(posedge clk);
         #1;
         p++;
      end while (cpuClkEn !== 1'b1 && p < 40);
   endtask

   task automatic settle(input logic [2:0] c);
      int i;
      for (i = 0; i < 40 && !(cpuDivActive === c && cpuDivPending === 1'b0); i++)
      begin
         @(posedge clk);
         #1;
      end
   endtask

   task automatic test_reset();
      @(posedge clk);
      #1;
      check({7'h00, periphClkEn}, 8'h01);
      check({5'h00, cpuDivActive}, 8'h01);
      rd(CCDS_CTL_ADDR, rv);
      check(rv, 8'h01);
      period(n);
      check(8'(n), 8'h02);
      $display("test done: reset");
   endtask

   task automatic test_ratios();
      int c;
      for (c = 0; c < 5; c++)
      begin
         wr(CCDS_CTL_ADDR, 1'b0, 3'h0, {5'h00, 3'(c)});
         settle(3'(c));
         rd(CCDS_CTL_ADDR, rv);
         check(rv, {5'h00, 3'(c)});
         period(n);
         check(8'(n), 8'(1 << c));
         check({7'h00, periphClkEn}, 8'h01);
      end
      // Last pulse was at /16, so a new code lands mid-period and must wait
      wr(CCDS_CTL_ADDR, 1'b0, 3'h0, 8'h01);
      @(posedge clk);
      #1;
      check({4'h0, cpuDivPending, cpuDivActive}, 8'h0C);
      settle(3'h1);
      period(n);
      check(8'(n), 8'h02);
      $display("test done: ratios");
   endtask

   task automatic test_bits();
      wr(CCDS_CTL_ADDR, 1'b1, 3'h2, 8'h01);
      rd(CCDS_CTL_ADDR, rv);
      check(rv, 8'h05);
      wr(CCDS_CTL_ADDR, 1'b1, 3'h0, 8'h00);
      wr(CCDS_CTL_ADDR, 1'b1, 3'h5, 8'h01);
      rd(CCDS_CTL_ADDR, rv);
      check(rv, 8'h04);
      settle(3'h4);
      period(n);
      check(8'(n), 8'h10);
      $display("test done: bits");
   endtask

   task automatic test_unmapped();
      wr(16'hFFFA, 1'b0, 3'h0, 8'h00);
      rd(16'hFFFA, rv);
      check(rv, 8'h00);
      rd(CCDS_CTL_ADDR, rv);
      check(rv, 8'h04);
      $display("test done: unmapped");
   endtask

   // Clock enable low must freeze outputs and drop a write
   task automatic test_freeze();
      logic [7:0] s;
      @(posedge clk);
      ce <= 1'b0;
      #1;
      s = {3'h0, cpuDivPending, cpuClkEn, cpuDivActive};
      wr(CCDS_CTL_ADDR, 1'b0, 3'h0, 8'h02);
      @(posedge clk);
      #1;
      check({3'h0, cpuDivPending, cpuClkEn, cpuDivActive}, s);
      check({5'h00, cpuDivActive}, 8'h04);
      @(posedge clk);
      ce <= 1'b1;
      rd(CCDS_CTL_ADDR, rv);
      check(rv, 8'h04);
      $display("test done: freeze");
   endtask

   // Second reset in mid-run must bring back divide by two
   task automatic test_rerun_reset();
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      #1;
      check({5'h00, cpuDivActive}, 8'h01);
      check({7'h00, periphClkEn}, 8'h01);
      rd(CCDS_CTL_ADDR, rv);
      check(rv, 8'h01);
      period(n);
      check(8'(n), 8'h02);
      $display("test done: rerun reset");
   endtask

   task automatic stop_test();
      $display("checked %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial
   begin
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      test_reset();
      test_ratios();
      test_bits();
      test_unmapped();
      test_freeze();
      test_rerun_reset();
      stop_test();
   end

   // Whole run needs well under a thousand cycles
   initial
   begin
      #20000;
      n_errors++;
      stop_test();
   end
endmodule // testbench
